// ==== verif/remote_io_master_channel_tb.sv ====
// Bench: master and slave ends joined by the line interface, RAM on the memory port.
// Assumes short bit divisors so a polling round takes a few thousand cycles.
`timescale 1ns/1ps
module remote_io_master_channel_tb;
	import rio_pkg::*;
	localparam int unsigned TB_DIV_LO = 16;
	localparam int unsigned TB_DIV_HI = 8;
	localparam int unsigned TB_TMO    = 600;

	logic        sys_clk;
	logic        arst_n;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] memAddr;
	logic        memRd;
	logic [15:0] memRdData;
	logic        memWr;
	logic [15:0] memWrData;
	logic        slvBaud;
	logic [15:0] inVal;
	logic [15:0] outWord;
	logic        outStrobe;
	logic [15:0] lastOut;
	logic [15:0] wrAddr;
	logic [15:0] wrData;
	logic [15:0] mem [0:65535];
	int          errorCnt;
	int          samplesChecked;

	rio_if link ();

	rio_master #(.DIV_LO(TB_DIV_LO), .DIV_HI(TB_DIV_HI), .REPLY_TMO(TB_TMO)) rio_master_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.memAddr(memAddr), .memRd(memRd), .memRdData(memRdData), .memWr(memWr),
		.memWrData(memWrData), .link(link));

	rio_slave #(.DIV_LO(TB_DIV_LO), .DIV_HI(TB_DIV_HI)) rio_slave_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .station(3'h1), .baudHi(slvBaud),
		.inWord(inVal), .outWord(outWord), .outStrobe(outStrobe), .link(link));

	rio_link_sva #(.DIV_LO(TB_DIV_LO), .DIV_HI(TB_DIV_HI), .REPLY_TMO(TB_TMO)) rio_link_sva_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .mOut(link.mOut), .mOe(link.mOe),
		.sOut(link.sOut), .sOe(link.sOe), .line(link.line));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Synchronous word RAM; also records the last slave output and master write
	always @(posedge sys_clk) begin
		if (memRd)
			memRdData <= mem[memAddr];
		if (memWr) begin
			mem[memAddr] <= memWrData;
			wrAddr <= memAddr;
			wrData <= memWrData;
		end
		if (outStrobe)
			lastOut <= outWord;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge sys_clk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'b1)
				break;
		end
		if (n == 100)
			errorCnt++;
		htrans <= 2'h0;
		hwdata <= wd;
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (hreadyout === 1'b1)
				break;
		end
		if (n == 100)
			errorCnt++;
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] unused;
		ahb(1'b1, a, d, unused);
	endtask

	task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(name, exp, d);
	endtask

	// Samples one 3-byte poll mid-bit on the line, start bit first
	task automatic frame(input int unsigned div, input logic [23:0] bytes);
		logic [29:0] seen;
		int          n;
		for (n = 0; n < 20000; n++) begin
			@(negedge sys_clk);
			if (link.mOe === 1'b1)
				break;
		end
		if (n == 20000)
			errorCnt++;
		repeat (div / 2) @(negedge sys_clk);
		for (n = 0; n < 30; n++) begin
			seen[n] = link.line;
			repeat (div) @(negedge sys_clk);
		end
		chk("poll frame", {3'h1, bytes[7:0], 2'b01, bytes[15:8], 2'b01, bytes[23:16], 1'b0},
			{2'h0, seen});
	endtask

	task automatic end_of_test();
		if (errorCnt == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		// Both rate passes need well under 10,000 cycles
		#300_000;
		errorCnt++;
		end_of_test();
	end

	initial begin
		logic [15:0] o;
		logic [31:0] d;
		int          b;
		int          n;
		arst_n = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		slvBaud = 1'b1;
		inVal = 16'h0;
		errorCnt = 0;
		samplesChecked = 0;
		foreach (mem[i])
			mem[i] = 16'h0;
		// Reserved block is nonzero on purpose; station 3 has one nonzero word only
		for (n = 0; n < 4; n++)
			mem[16'h0100 + n] = 16'hFFFF;
		mem[16'h0104] = 16'h0200;
		mem[16'h0105] = 16'h0010;
		mem[16'h0106] = 16'h0300;
		mem[16'h0107] = 16'h0008;
		mem[16'h010D] = 16'h0008;
		mem[16'h0114] = 16'h0210;
		mem[16'h0115] = 16'h0FA0;
		mem[16'h0116] = 16'h0310;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		rdchk("ctrl", {24'h0, REG_CTRL}, 32'h1);
		rdchk("table", {24'h0, REG_TABLE}, {16'h0, TABLE_DEFAULT});
		rdchk("status", {24'h0, REG_STATUS}, 32'h0);
		wr(32'hC, 32'hFFFF_FFFF);
		rdchk("unmapped", 32'hC, 32'h0);
		wr({24'h0, REG_TABLE}, 32'h0100);
		rdchk("table", {24'h0, REG_TABLE}, 32'h0100);
		wr({24'h0, REG_CTRL}, 32'h15);
		rdchk("status", {24'h0, REG_STATUS}, 32'h0001_0000);
		wr({24'h0, REG_CTRL}, 32'h1);
		// High rate first, then the fallback low rate
		for (b = 1; b >= 0; b--) begin
			o = b ? 16'hA55A : 16'h5AA5;
			mem[16'h0300] = o;
			inVal <= b ? 16'h1234 : 16'h4321;
			slvBaud <= b[0];
			wr({24'h0, REG_CTRL}, {27'h0, 1'b1, 3'h0, b[0]});
			frame(b ? TB_DIV_HI : TB_DIV_LO, {8'h01, o});
			frame(b ? TB_DIV_HI : TB_DIV_LO, 24'h030000);
			frame(b ? TB_DIV_HI : TB_DIV_LO, {8'h01, o});
			wr({24'h0, REG_CTRL}, {31'h0, b[0]});
			for (n = 0; n < 2000; n++) begin
				ahb(1'b0, {24'h0, REG_STATUS}, 32'h0, d);
				if (d[STAT_RUN] === 1'b0)
					break;
			end
			chk("out word", {16'h0, o}, {16'h0, lastOut});
			chk("in addr", 32'h0200, {16'h0, wrAddr});
			chk("in data", {16'h0, inVal}, {16'h0, wrData});
			rdchk("status", {24'h0, REG_STATUS}, 32'h0000_8402);
			wr({24'h0, REG_STATUS}, 32'h8000);
			rdchk("status", {24'h0, REG_STATUS}, 32'h0000_0402);
		end
		end_of_test();
	end
endmodule

// ==== verif/rio_link_sva.sv ====
// Checker for the half-duplex line between the master and slave ends.
// Assumes both ends run with the bit divisors handed in here.
`timescale 1ns/1ps
module rio_link_sva #(
	parameter int unsigned DIV_LO    = 16,
	parameter int unsigned DIV_HI    = 8,
	parameter int unsigned REPLY_TMO = 600
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Line signals
	input wire logic mOut,
	input wire logic mOe,
	input wire logic sOut,
	input wire logic sOe,
	input wire logic line
);
	int unsigned mCnt;
	int unsigned sCnt;
	int unsigned gapCnt;
	logic        polled;
	logic        replied;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Frame lengths; a gap between bytes would show up here
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mCnt <= 0;
			sCnt <= 0;
		end else begin
			mCnt <= mOe ? mCnt + 1 : 0;
			sCnt <= sOe ? sCnt + 1 : 0;
		end
	end

	// Silence since the last poll, and whether the slave spoke in it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gapCnt <= 0;
			polled <= 1'b0;
			replied <= 1'b0;
		end else begin
			gapCnt <= mOe ? 0 : gapCnt + 1;
			polled <= polled | mOe;
			replied <= mOe ? 1'b0 : (replied | sOe);
		end
	end

	property p_half_duplex;
		!(mOe && sOe);
	endproperty
	a_half_duplex: assert property (p_half_duplex)
		else $error("both ends drive the line");

	property p_m_start;
		$rose(mOe) |-> (!mOut) [*8];
	endproperty
	a_m_start: assert property (p_m_start)
		else $error("master start bit too short");

	property p_m_frame;
		$fell(mOe) |-> mCnt == 30 * DIV_HI || mCnt == 30 * DIV_LO;
	endproperty
	a_m_frame: assert property (p_m_frame)
		else $error("master frame length wrong");

	property p_m_stop;
		$fell(mOe) |-> $past(line) && $past(mOut);
	endproperty
	a_m_stop: assert property (p_m_stop)
		else $error("master frame not ended by a stop bit");

	property p_s_gap;
		$fell(mOe) |-> (!sOe) [*8];
	endproperty
	a_s_gap: assert property (p_s_gap)
		else $error("slave answered without turnaround gap");

	property p_s_start;
		$rose(sOe) |-> !sOut ##1 !sOut;
	endproperty
	a_s_start: assert property (p_s_start)
		else $error("slave start bit wrong");

	property p_s_frame;
		$fell(sOe) |-> sCnt == 30 * DIV_HI || sCnt == 30 * DIV_LO;
	endproperty
	a_s_frame: assert property (p_s_frame)
		else $error("slave frame length wrong");

	property p_wait_reply;
		$rose(mOe) && polled |-> replied || gapCnt >= REPLY_TMO;
	endproperty
	a_wait_reply: assert property (p_wait_reply)
		else $error("new poll before reply or timeout");
endmodule

// ==== verilog/rio_if.sv ====
// Half-duplex remote I/O line joining master and slave ends.
// Line idles high when nobody drives it (pull-up).
`timescale 1ns/1ps
interface rio_if;
	logic mOut;
	logic mOe;
	logic sOut;
	logic sOe;
	wire  line;

	assign line = mOe ? mOut : (sOe ? sOut : 1'b1);

	modport master (output mOut, output mOe, input line);
	modport slave  (output sOut, output sOe, input line);
endinterface

// ==== verilog/rio_master.sv ====
// Master end of the built-in remote I/O channel, with AHB-Lite registers
// and a word-memory port. Assumes a synchronous RAM on the memory port
// that returns read data the cycle after it samples memRd.
//
// Operation
// [R1] Station number zero makes this the master
// [R2] Stations one to seven belong to slaves
// [R3] Bit rate is 19200 or 38400 only
// [R4] Start at 38400, fall back on errors; code resets to 38400, falls back only when software writes CTRL
// [R5] Slaves must match the master bit rate
// [R6] Table start programmable, default word 37700 octal
// [R7] Channel table independent of other master tables
// [R8] Table is four-word blocks, one per slave
// [R9] First block reserved; slaves start word five
// [R10] After setup, blocks read as slave parameters
// [R11] Seven bases, at most 2048 points
// [R12] Older firmware limits channel to 512 points
// [R13] Remote points live apart from local image
// [R14] One shared half-duplex line, never both directions
// [R15] Block: input addr, input count, output addr, count
// [R16] Table 32 words, absent slaves all zero
// [R17] Any nonzero block word means slave present
// [R18] Setup-done relay starts remote communication
// [R19] Poll slaves one at a time, ascending
// [R20] No new transmit until exchange ends or times out
`timescale 1ns/1ps
module rio_master
	import rio_pkg::*;
#(
	parameter int unsigned DIV_LO      = BAUD_DIV_LO,
	parameter int unsigned DIV_HI      = BAUD_DIV_HI,
	parameter int unsigned REPLY_TMO   = REPLY_TMO_CYC,
	parameter bit          LEGACY_FW   = 1'b0
)(
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// AHB-Lite register slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Word memory port
	output logic      [15:0] memAddr,
	output logic             memRd,
	input  wire logic [15:0] memRdData,
	output logic             memWr,
	output logic      [15:0] memWrData,
	// Link
	rio_if.master            link
);
	typedef enum logic [4:0] {
		MS_IDLE  = 5'b00001,
		MS_FETCH = 5'b00010,
		MS_TX    = 5'b00100,
		MS_RX    = 5'b01000,
		MS_NEXT  = 5'b10000
	} rio_ms_state_t;

	localparam int unsigned POINT_LIMIT = LEGACY_FW ? LEGACY_POINTS : MAX_POINTS; // see [R12]

	// Software-visible state
	logic          baudHi_reg;
	logic [2:0]    ownStation_reg;
	logic          setupDone_reg;
	logic [15:0]   tableBase_reg;
	logic          pointsOver_reg;
	logic [6:0]    present_reg;
	logic [6:0]    timeout_reg;
	// Bus pipeline
	logic          wrPend_reg;
	logic [7:0]    regAddr_reg;
	// Poll engine
	rio_ms_state_t fsm_reg;
	logic [2:0]    station_reg;
	logic [2:0]    cnt_reg;
	logic [15:0]   blk_reg [BLOCK_WORDS];
	logic [15:0]   outData_reg;
	logic [17:0]   total_reg;
	logic          overEvt_reg;
	logic [12:0]   baudCnt_reg;
	logic [3:0]    bitIdx_reg;
	logic [1:0]    byteIdx_reg;
	logic          rxBusy_reg;
	logic [7:0]    rxShift_reg;
	logic          stationOk_reg;
	logic [7:0]    rxHi_reg;
	logic [9:0]    txShift_reg;
	logic [19:0]   tmo_reg;

	logic          addrPhase;
	logic          linkEnable;
	logic [12:0]   bitDiv;
	logic [17:0]   newTotal;
	logic          blkPresent;
	logic [6:0]    stBit;

	// Polling runs only as master and only once the program says the table is ready
	assign linkEnable = setupDone_reg && ownStation_reg == MASTER_STATION; // see [R1] [R18]
	assign addrPhase  = hsel && htrans[1] && hready;
	assign bitDiv     = baudHi_reg ? 13'(DIV_HI - 1) : 13'(DIV_LO - 1); // see [R3]
	assign blkPresent = |{blk_reg[0], blk_reg[1], blk_reg[2], blk_reg[3]}; // see [R17]
	assign newTotal   = total_reg + 18'(blk_reg[1]) + 18'(blk_reg[3]);
	assign stBit      = 7'(7'h01 << (station_reg - 3'h1));

	function automatic logic [31:0] regRead(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			REG_CTRL: begin
				v[CTRL_BAUD_HI]            = baudHi_reg;
				v[CTRL_STATION +: 3]       = ownStation_reg;
				v[CTRL_SETUP]              = setupDone_reg;
			end
			REG_TABLE: v[15:0] = tableBase_reg;
			REG_STATUS: begin
				v[STAT_RUN]                = fsm_reg != MS_IDLE;
				v[STAT_PRESENT +: 7]       = present_reg;
				v[STAT_TIMEOUT +: 7]       = timeout_reg;
				v[STAT_OVER]               = pointsOver_reg;
				v[STAT_CFG_ERR]            = ownStation_reg != MASTER_STATION;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// AHB-Lite: zero wait states, reads answered from the address phase
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPend_reg  <= 1'b0;
			regAddr_reg <= 8'h00;
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else if (ce) begin
			wrPend_reg <= addrPhase && hwrite;
			if (addrPhase)
				regAddr_reg <= haddr[7:0];
			if (addrPhase && !hwrite)
				hrdata <= regRead(haddr[7:0]);
		end
	end

	// Control registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			baudHi_reg     <= CTRL_BAUD_RST; // see [R4]
			ownStation_reg <= CTRL_STAT_RST;
			setupDone_reg  <= 1'b0;
			tableBase_reg  <= TABLE_DEFAULT; // see [R6]
		end else if (ce && wrPend_reg) begin
			if (regAddr_reg == REG_CTRL) begin
				baudHi_reg     <= hwdata[CTRL_BAUD_HI];
				ownStation_reg <= hwdata[CTRL_STATION +: 3];
				setupDone_reg  <= hwdata[CTRL_SETUP];
			end
			// Private to this channel; no other master shares it
			if (regAddr_reg == REG_TABLE)
				tableBase_reg <= hwdata[15:0]; // see [R7]
		end
	end

	// Point-budget overflow: sticky, write 1 to clear, a new event wins
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			pointsOver_reg <= 1'b0;
		else if (ce) begin
			if (overEvt_reg)
				pointsOver_reg <= 1'b1;
			else if (wrPend_reg && regAddr_reg == REG_STATUS && hwdata[STAT_OVER])
				pointsOver_reg <= 1'b0;
		end
	end

	// Poll engine
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fsm_reg       <= MS_IDLE;
			station_reg   <= 3'h1;
			cnt_reg       <= 3'h0;
			for (int i = 0; i < BLOCK_WORDS; i++)
				blk_reg[i] <= 16'h0000;
			outData_reg   <= 16'h0000;
			total_reg     <= 18'h00000;
			overEvt_reg   <= 1'b0;
			present_reg   <= 7'h00;
			timeout_reg   <= 7'h00;
			baudCnt_reg   <= 13'h0000;
			bitIdx_reg    <= 4'h0;
			byteIdx_reg   <= 2'h0;
			rxBusy_reg    <= 1'b0;
			rxShift_reg   <= 8'h00;
			stationOk_reg <= 1'b0;
			rxHi_reg      <= 8'h00;
			txShift_reg   <= 10'h3FF;
			tmo_reg       <= 20'h00000;
			memAddr       <= 16'h0000;
			memRd         <= 1'b0;
			memWr         <= 1'b0;
			memWrData     <= 16'h0000;
			link.mOut     <= 1'b1;
			link.mOe      <= 1'b0;
		end else if (ce) begin
			memRd       <= 1'b0;
			memWr       <= 1'b0;
			overEvt_reg <= 1'b0;
			case (fsm_reg)
				MS_IDLE: begin
					link.mOe <= 1'b0;
					if (linkEnable) begin
						station_reg <= 3'h1; // see [R2] [R9]
						cnt_reg     <= 3'h0;
						total_reg   <= 18'h00000;
						fsm_reg     <= MS_FETCH;
					end
				end
				MS_FETCH: begin
					// Reads of the four block words are pipelined, then the output word
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg <= 3'h3) begin
						memRd   <= 1'b1;
						memAddr <= tableBase_reg + {11'h000, station_reg, 2'h0}
							+ {14'h0000, cnt_reg[1:0]}; // see [R8] [R9] [R10]
					end
					if (cnt_reg == 3'h4) begin
						memRd   <= 1'b1;
						memAddr <= memRdData;
					end
					if (cnt_reg >= 3'h2 && cnt_reg <= 3'h5)
						blk_reg[cnt_reg[1:0] - 2'h2] <= memRdData; // see [R15]
					if (cnt_reg == 3'h6) begin
						outData_reg <= memRdData;
						if (!blkPresent) begin
							fsm_reg <= MS_NEXT; // see [R16]
						end else if (newTotal > 18'(POINT_LIMIT)) begin
							overEvt_reg <= 1'b1; // see [R11]
							fsm_reg     <= MS_NEXT;
						end else begin
							total_reg   <= newTotal;
							txShift_reg <= {1'b1, 5'h00, station_reg, 1'b0};
							link.mOut   <= 1'b0;
							link.mOe    <= 1'b1; // see [R14]
							baudCnt_reg <= bitDiv;
							bitIdx_reg  <= 4'h0;
							byteIdx_reg <= 2'h0;
							fsm_reg     <= MS_TX;
						end
					end
				end
				MS_TX: begin
					if (baudCnt_reg != 13'h0000) begin
						baudCnt_reg <= baudCnt_reg - 13'h0001;
					end else begin
						baudCnt_reg <= bitDiv;
						if (bitIdx_reg == 4'h9) begin
							bitIdx_reg <= 4'h0;
							if (byteIdx_reg == 2'h2) begin
								// Release the line before listening
								link.mOe    <= 1'b0; // see [R14]
								byteIdx_reg <= 2'h0;
								rxBusy_reg  <= 1'b0;
								tmo_reg     <= 20'h00000;
								fsm_reg     <= MS_RX;
							end else begin
								byteIdx_reg <= byteIdx_reg + 2'h1;
								txShift_reg <= {1'b1, (byteIdx_reg == 2'h0) ?
									outData_reg[15:8] : outData_reg[7:0], 1'b0};
								link.mOut   <= 1'b0;
							end
						end else begin
							bitIdx_reg  <= bitIdx_reg + 4'h1;
							txShift_reg <= {1'b1, txShift_reg[9:1]};
							link.mOut   <= txShift_reg[1];
						end
					end
				end
				MS_RX: begin
					tmo_reg <= tmo_reg + 20'h00001;
					if (tmo_reg == 20'(REPLY_TMO - 1)) begin
						timeout_reg <= timeout_reg | stBit; // see [R20]
						present_reg <= present_reg & ~stBit;
						fsm_reg     <= MS_NEXT;
					end else if (!rxBusy_reg) begin
						if (!link.line) begin
							rxBusy_reg  <= 1'b1;
							baudCnt_reg <= {1'b0, bitDiv[12:1]};
							bitIdx_reg  <= 4'h0;
						end
					end else if (baudCnt_reg != 13'h0000) begin
						baudCnt_reg <= baudCnt_reg - 13'h0001;
					end else begin
						baudCnt_reg <= bitDiv;
						bitIdx_reg  <= bitIdx_reg + 4'h1;
						if (bitIdx_reg == 4'h0) begin
							if (link.line)
								rxBusy_reg <= 1'b0;
						end else if (bitIdx_reg <= 4'h8) begin
							rxShift_reg <= {link.line, rxShift_reg[7:1]};
						end else begin
							rxBusy_reg  <= 1'b0;
							byteIdx_reg <= byteIdx_reg + 2'h1;
							if (byteIdx_reg == 2'h0)
								stationOk_reg <= rxShift_reg == {5'h00, station_reg};
							if (byteIdx_reg == 2'h1)
								rxHi_reg <= rxShift_reg;
							if (byteIdx_reg == 2'h2) begin
								fsm_reg <= MS_NEXT;
								if (stationOk_reg) begin
									// Inputs land at the slave's own address, not local X
									memWr       <= 1'b1; // see [R13]
									memAddr     <= blk_reg[0];
									memWrData   <= {rxHi_reg, rxShift_reg};
									present_reg <= present_reg | stBit;
									timeout_reg <= timeout_reg & ~stBit;
								end else begin
									timeout_reg <= timeout_reg | stBit;
								end
							end
						end
					end
				end
				MS_NEXT: begin
					cnt_reg <= 3'h0;
					if (!linkEnable) begin
						fsm_reg <= MS_IDLE;
					end else if (station_reg == LAST_STATION) begin
						station_reg <= 3'h1; // see [R19]
						total_reg   <= 18'h00000;
						fsm_reg     <= MS_FETCH;
					end else begin
						station_reg <= station_reg + 3'h1;
						fsm_reg     <= MS_FETCH;
					end
				end
				default: fsm_reg <= MS_IDLE;
			endcase
		end
	end
endmodule

// ==== verilog/rio_pkg.sv ====
// Constants shared by both ends of the remote I/O link.
// Assumes a 100 MHz system clock on both ends.
package rio_pkg;
	// Clock and link rates
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned BAUD_LO       = 19200;
	localparam int unsigned BAUD_HI       = 38400;
	localparam int unsigned BAUD_DIV_LO   = CLK_HZ / BAUD_LO;
	localparam int unsigned BAUD_DIV_HI   = CLK_HZ / BAUD_HI;
	localparam int unsigned REPLY_BITS    = 40;
	localparam int unsigned REPLY_TMO_CYC = REPLY_BITS * BAUD_DIV_LO;

	// Stations and table layout
	localparam logic [2:0]  MASTER_STATION = 3'h0;
	localparam logic [2:0]  LAST_STATION   = 3'h7;
	localparam int unsigned BLOCK_WORDS    = 4;
	localparam int unsigned TABLE_WORDS    = 32;
	localparam logic [15:0] TABLE_DEFAULT  = 16'h3FC0;
	localparam int unsigned MAX_POINTS     = 2048;
	localparam int unsigned LEGACY_POINTS  = 512;
	localparam int unsigned FRAME_BYTES    = 3;

	// Register map (byte offsets)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_TABLE  = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;

	// Field positions
	localparam int CTRL_BAUD_HI  = 0;
	localparam int CTRL_STATION  = 1;
	localparam int CTRL_SETUP    = 4;
	localparam int STAT_RUN      = 0;
	localparam int STAT_PRESENT  = 1;
	localparam int STAT_TIMEOUT  = 8;
	localparam int STAT_OVER     = 15;
	localparam int STAT_CFG_ERR  = 16;

	// Reset values
	localparam logic       CTRL_BAUD_RST  = 1'b1;
	localparam logic [2:0] CTRL_STAT_RST  = 3'h0;
endpackage

// ==== verilog/rio_slave.sv ====
// Slave end of the remote I/O link: answers polls for its station.
// Assumes the master leaves a silent line after each 3-byte poll.
`timescale 1ns/1ps
module rio_slave
	import rio_pkg::*;
#(
	parameter int unsigned DIV_LO = BAUD_DIV_LO,
	parameter int unsigned DIV_HI = BAUD_DIV_HI
)(
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// Configuration straps
	input  wire logic [2:0]  station,
	input  wire logic        baudHi,
	// User side
	input  wire logic [15:0] inWord,
	output logic      [15:0] outWord,
	output logic             outStrobe,
	// Link
	rio_if.slave             link
);
	typedef enum logic [2:0] {
		SL_LISTEN = 3'b001,
		SL_GAP    = 3'b010,
		SL_TX     = 3'b100
	} rio_sl_state_t;

	rio_sl_state_t fsm_reg;
	logic [12:0]   baudCnt_reg;
	logic [3:0]    bitIdx_reg;
	logic [1:0]    byteIdx_reg;
	logic          rxBusy_reg;
	logic [7:0]    rxShift_reg;
	logic [7:0]    b0_reg;
	logic [7:0]    b1_reg;
	logic [9:0]    txShift_reg;
	logic [15:0]   txData_reg;
	logic [12:0]   bitDiv;

	assign bitDiv = baudHi ? 13'(DIV_HI - 1) : 13'(DIV_LO - 1); // see [R3] [R5]

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fsm_reg     <= SL_LISTEN;
			baudCnt_reg <= 13'h0000;
			bitIdx_reg  <= 4'h0;
			byteIdx_reg <= 2'h0;
			rxBusy_reg  <= 1'b0;
			rxShift_reg <= 8'h00;
			b0_reg      <= 8'h00;
			b1_reg      <= 8'h00;
			txShift_reg <= 10'h3FF;
			txData_reg  <= 16'h0000;
			outWord     <= 16'h0000;
			outStrobe   <= 1'b0;
			link.sOut   <= 1'b1;
			link.sOe    <= 1'b0;
		end else if (ce) begin
			outStrobe <= 1'b0;
			case (fsm_reg)
				SL_LISTEN: begin
					link.sOe <= 1'b0;
					if (!rxBusy_reg) begin
						if (!link.line) begin
							rxBusy_reg  <= 1'b1;
							baudCnt_reg <= {1'b0, bitDiv[12:1]};
							bitIdx_reg  <= 4'h0;
						end
					end else if (baudCnt_reg != 13'h0000) begin
						baudCnt_reg <= baudCnt_reg - 13'h0001;
					end else begin
						baudCnt_reg <= bitDiv;
						bitIdx_reg  <= bitIdx_reg + 4'h1;
						if (bitIdx_reg == 4'h0) begin
							if (link.line)
								rxBusy_reg <= 1'b0;
						end else if (bitIdx_reg <= 4'h8) begin
							rxShift_reg <= {link.line, rxShift_reg[7:1]};
						end else begin
							rxBusy_reg <= 1'b0;
							if (byteIdx_reg == 2'h0)
								b0_reg <= rxShift_reg;
							if (byteIdx_reg == 2'h1)
								b1_reg <= rxShift_reg;
							if (byteIdx_reg == 2'h2) begin
								byteIdx_reg <= 2'h0;
								// Station 0 belongs to the master, never answered here
								if (b0_reg == {5'h00, station} &&
										station != MASTER_STATION) begin // see [R2]
									outWord     <= {b1_reg, rxShift_reg};
									outStrobe   <= 1'b1;
									txData_reg  <= inWord;
									// Rest of the stop bit plus one bit time, so the
									// master has let go of the line before we drive it
									baudCnt_reg <= bitDiv + {1'b0, bitDiv[12:1]} + 13'h0001;
									fsm_reg     <= SL_GAP;
								end
							end else begin
								byteIdx_reg <= byteIdx_reg + 2'h1;
							end
						end
					end
				end
				SL_GAP: begin
					// One bit time of silence lets the master release the line
					if (baudCnt_reg != 13'h0000) begin
						baudCnt_reg <= baudCnt_reg - 13'h0001;
					end else begin
						baudCnt_reg <= bitDiv;
						txShift_reg <= {1'b1, 5'h00, station, 1'b0};
						link.sOut   <= 1'b0;
						link.sOe    <= 1'b1; // see [R14]
						bitIdx_reg  <= 4'h0;
						byteIdx_reg <= 2'h0;
						fsm_reg     <= SL_TX;
					end
				end
				SL_TX: begin
					if (baudCnt_reg != 13'h0000) begin
						baudCnt_reg <= baudCnt_reg - 13'h0001;
					end else begin
						baudCnt_reg <= bitDiv;
						if (bitIdx_reg == 4'h9) begin
							bitIdx_reg <= 4'h0;
							if (byteIdx_reg == 2'h2) begin
								link.sOe    <= 1'b0;
								byteIdx_reg <= 2'h0;
								fsm_reg     <= SL_LISTEN;
							end else begin
								byteIdx_reg <= byteIdx_reg + 2'h1;
								txShift_reg <= {1'b1, (byteIdx_reg == 2'h0) ?
									txData_reg[15:8] : txData_reg[7:0], 1'b0};
								link.sOut   <= 1'b0;
							end
						end else begin
							bitIdx_reg  <= bitIdx_reg + 4'h1;
							txShift_reg <= {1'b1, txShift_reg[9:1]};
							link.sOut   <= txShift_reg[1];
						end
					end
				end
				default: fsm_reg <= SL_LISTEN;
			endcase
		end
	end
endmodule
